// [rtl/isbe_engine.sv]
// Purpose: two-wire bus master/slave byte engine with Avalon-MM registers
// Assumes: scl_i and sda_i are synchronous to clk; word addressed slave port
// Notes: pins are open drain; an oe_n low pulls the line low
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module isbe_engine
  import isbe_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  localparam logic [15:0] HALF_M1 = 16'(HALF_CYCLES - 1);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] own;
    logic [7:0] sec;
    logic [7:0] lth;
    logic [7:0] ltl;
    logic [7:0] data;
    logic full;
    logic [1:0] errs;
    logic buf_err;
    isbe_mstate_t ms;
    logic [15:0] cnt;
    logic [3:0] mbit;
    logic [7:0] msh;
    logic mrx;
    logic mstop;
    logic mown;
    logic msamp;
    logic mscl_low;
    logic msda_low;
    logic scl_p;
    logic sda_p;
    logic busy;
    logic arb_lost;
    logic nack;
    logic done;
    logic lto;
    logic cmd_err;
    logic [3:0] scnt;
    logic sfirst;
    logic ssel;
    logic srw;
    logic snack;
    logic [7:0] srx;
    logic [7:0] stx;
    logic s_low;
    logic scl_oe_n;
    logic sda_oe_n;
    logic pin_lvl;
  } isbe_state_t;

  isbe_state_t st_r;
  isbe_state_t st_nxt;
  logic lto_pulse;
  logic [31:0] rmux;
  logic [7:0] stat_v;
  logic [7:0] wd;
  logic acc;
  logic wr;
  logic rd;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic bus_free;
  logic tdone;
  logic start_ok;

  assign start_det = st_r.scl_p & scl_i & st_r.sda_p & ~sda_i;
  assign stop_det = st_r.scl_p & scl_i & ~st_r.sda_p & sda_i;
  assign scl_rise = scl_i & ~st_r.scl_p;
  assign scl_fall = ~scl_i & st_r.scl_p;
  assign bus_free = ~st_r.busy & scl_i & sda_i;
  assign tdone = (st_r.cnt >= HALF_M1);

  isbe_timeout u_timeout (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .scl_i(scl_i),
    .fast_sel(st_r.ctrl[CTRL_TCK_SEL]),
    .limit({st_r.lth, st_r.ltl}),
    .expired(lto_pulse)
  );

  always_comb begin
    st_nxt = st_r;
    rmux = 32'h0;
    stat_v = 8'h00;
    start_ok = 1'h0;
    wd = avs_writedata[7:0];
    acc = (avs_read | avs_write) & ~st_r.waitreq;
    wr = acc & avs_write & avs_byteenable[0];
    rd = acc & avs_read;
    st_nxt.waitreq = 1'h1;
    st_nxt.scl_p = scl_i;
    st_nxt.sda_p = sda_i;
    st_nxt.cnt = st_r.cnt + 16'h0001;
    stat_v[ST_BUSY] = st_r.busy;
    stat_v[ST_MOWN] = st_r.mown;
    stat_v[ST_ARB] = st_r.arb_lost;
    stat_v[ST_NACK] = st_r.nack;
    stat_v[ST_DONE] = st_r.done;
    stat_v[ST_SEL] = st_r.ssel;
    stat_v[ST_LTO] = st_r.lto;
    stat_v[ST_CERR] = st_r.cmd_err;
    case (avs_address)
      IDX_CTRL: rmux[7:0] = st_r.ctrl;
      IDX_OWN: rmux[7:0] = st_r.own;
      IDX_DATA: rmux[7:0] = st_r.data;
      IDX_STAT: rmux[7:0] = stat_v;
      IDX_SEC: rmux[7:0] = {st_r.sec[7:1], 1'h0};
      IDX_LTH: rmux[7:0] = st_r.lth;
      IDX_LTL: rmux[7:0] = st_r.ltl;
      IDX_BUF: rmux[7:0] = {6'h00, st_r.buf_err, ~st_r.full};
      default: rmux = 32'h0;
    endcase
    // one wait cycle, then the access completes
    if ((avs_read | avs_write) & st_r.waitreq) begin
      st_nxt.waitreq = 1'h0;
      st_nxt.rdata = rmux;
    end
    if (start_det) begin
      st_nxt.busy = 1'h1;
    end else if (stop_det) begin
      st_nxt.busy = 1'h0;
    end

    if (wr) begin
      case (avs_address)
        IDX_CTRL: st_nxt.ctrl = wd & CTRL_MASK;
        IDX_OWN: st_nxt.own = {wd[7:1], 1'h0};
        IDX_DATA: begin
          if (st_r.full && st_r.busy) begin
            if (st_r.errs != ERR_LIMIT) st_nxt.errs = st_r.errs + 2'h1;
          end else begin
            st_nxt.data = wd;
            st_nxt.full = 1'h1;
          end
        end
        IDX_STAT: begin
          if (wd[ST_ARB]) st_nxt.arb_lost = 1'h0;
          if (wd[ST_DONE]) st_nxt.done = 1'h0;
          if (wd[ST_LTO]) st_nxt.lto = 1'h0;
          if (wd[ST_CERR]) st_nxt.cmd_err = 1'h0;
        end
        IDX_SEC: st_nxt.sec = {wd[7:1], 1'h0};
        IDX_LTH: st_nxt.lth = wd;
        IDX_LTL: st_nxt.ltl = wd;
        IDX_BUF: begin
          if (wd[BUF_ERR]) begin
            st_nxt.buf_err = 1'h0;
            st_nxt.errs = 2'h0;
          end
        end
        default: ;
      endcase
    end
    if (rd && (avs_address == IDX_DATA)) begin
      if (!st_r.full && st_r.busy) begin
        if (st_r.errs != ERR_LIMIT) st_nxt.errs = st_r.errs + 2'h1;
      end else begin
        st_nxt.full = 1'h0;
      end
    end
    if (st_nxt.errs == ERR_LIMIT) st_nxt.buf_err = 1'h1;

    case (st_r.ms)
      MS_IDLE: begin
        st_nxt.mscl_low = 1'h0;
        st_nxt.msda_low = 1'h0;
      end
      MS_REL: begin
        st_nxt.msda_low = 1'h0;
        if (tdone) begin
          st_nxt.ms = MS_SETUP;
          st_nxt.mscl_low = 1'h0;
          st_nxt.cnt = 16'h0000;
        end
      end
      MS_SETUP: begin
        // wait while another device holds clock low
        if (!scl_i) begin
          st_nxt.cnt = 16'h0000;
        end else if (tdone) begin
          st_nxt.cnt = 16'h0000;
          st_nxt.ms = st_r.mstop ? MS_STPE : MS_STA;
          st_nxt.msda_low = ~st_r.mstop;
        end
      end
      MS_STA: begin
        if (tdone) begin
          st_nxt.ms = MS_LOW;
          st_nxt.mscl_low = 1'h1;
          st_nxt.cnt = 16'h0000;
        end
      end
      MS_LOW: begin
        // data set one cycle after clock went low
        if (st_r.cnt == 16'h0000) begin
          if (st_r.mbit < 4'h8) begin
            st_nxt.msda_low = ~st_r.mrx & ~st_r.msh[7];
          end else begin
            // software sets nack before a restart
            st_nxt.msda_low = st_r.mrx & ~st_r.ctrl[CTRL_TXAK];
          end
        end
        if (tdone) begin
          st_nxt.ms = MS_HIGH;
          st_nxt.mscl_low = 1'h0;
          st_nxt.cnt = 16'h0000;
        end
      end
      MS_HIGH: begin
        if (!st_r.msamp) begin
          st_nxt.cnt = 16'h0000;
          if (scl_i) begin
            st_nxt.msamp = 1'h1;
            if (st_r.mbit < 4'h8) begin
              // released one but bus is low
              if (!st_r.mrx && st_r.msh[7] && !sda_i) begin
                st_nxt.ms = MS_IDLE;
                st_nxt.mown = 1'h0;
                st_nxt.msamp = 1'h0;
                st_nxt.mscl_low = 1'h0;
                st_nxt.msda_low = 1'h0;
                st_nxt.arb_lost = 1'h1;
              end else begin
                st_nxt.msh = {st_r.msh[6:0], sda_i};
              end
            end else begin
              // high on ninth clock is a failed transfer
              st_nxt.nack = sda_i;
            end
          end
        end else if (tdone || !scl_i) begin
          // high time ends with the fastest device
          st_nxt.mscl_low = 1'h1;
          st_nxt.msamp = 1'h0;
          st_nxt.cnt = 16'h0000;
          if (st_r.mbit == 4'h8) begin
            st_nxt.ms = MS_HOLD;
            st_nxt.mbit = 4'h0;
            st_nxt.done = 1'h1;
            if (st_r.mrx) begin
              st_nxt.data = st_r.msh;
              st_nxt.full = 1'h1;
            end
          end else begin
            st_nxt.mbit = st_r.mbit + 4'h1;
            st_nxt.ms = MS_LOW;
          end
        end
      end
      MS_HOLD: begin
        st_nxt.mscl_low = 1'h1;
        st_nxt.msda_low = 1'h0;
      end
      MS_STP1: begin
        st_nxt.msda_low = 1'h1;
        if (tdone) begin
          st_nxt.ms = MS_SETUP;
          st_nxt.mscl_low = 1'h0;
          st_nxt.cnt = 16'h0000;
        end
      end
      MS_STPE: begin
        st_nxt.msda_low = 1'h0;
        if (tdone) begin
          st_nxt.ms = MS_IDLE;
          st_nxt.mown = 1'h0;
          st_nxt.mstop = 1'h0;
        end
      end
      default: st_nxt.ms = MS_IDLE;
    endcase

    if (wr && (avs_address == IDX_CMD)) begin
      // a refused command must not disturb a byte in flight
      if (st_r.ms == MS_IDLE || st_r.ms == MS_HOLD) begin
        st_nxt.cnt = 16'h0000;
        st_nxt.mbit = 4'h0;
        st_nxt.msamp = 1'h0;
      end
      case (wd[2:0])
        CMD_START: begin
          // refuse own address or an active slave session
          if (!st_r.full || st_r.ssel || (st_r.data[7:1] == st_r.own[7:1])) begin
            st_nxt.cmd_err = 1'h1;
          // fresh start only on a free bus
          end else if (st_r.ms == MS_IDLE && bus_free) begin
            st_nxt.ms = MS_STA;
            st_nxt.msda_low = 1'h1;
            start_ok = 1'h1;
          // repeated start from a held bus
          end else if (st_r.ms == MS_HOLD) begin
            st_nxt.ms = MS_REL;
            start_ok = 1'h1;
          end else begin
            st_nxt.cmd_err = 1'h1;
          end
          // sticky error flag from an older command must not block this one
          if (start_ok) begin
            st_nxt.msh = st_r.data;
            st_nxt.full = 1'h0;
            st_nxt.mrx = 1'h0;
            st_nxt.mown = 1'h1;
            st_nxt.mstop = 1'h0;
          end
        end
        CMD_TX: begin
          if (st_r.ms == MS_HOLD && st_r.full) begin
            st_nxt.ms = MS_LOW;
            st_nxt.msh = st_r.data;
            st_nxt.full = 1'h0;
            st_nxt.mrx = 1'h0;
          end else begin
            st_nxt.cmd_err = 1'h1;
          end
        end
        CMD_RX: begin
          if (st_r.ms == MS_HOLD) begin
            st_nxt.ms = MS_LOW;
            st_nxt.mrx = 1'h1;
          end else begin
            st_nxt.cmd_err = 1'h1;
          end
        end
        CMD_STOP: begin
          if (st_r.ms == MS_HOLD) begin
            st_nxt.ms = MS_STP1;
            st_nxt.mstop = 1'h1;
          end else begin
            st_nxt.cmd_err = 1'h1;
          end
        end
        default: st_nxt.cmd_err = 1'h1;
      endcase
    end

    if (start_det) begin
      st_nxt.scnt = 4'h0;
      st_nxt.sfirst = 1'h1;
      st_nxt.ssel = 1'h0;
      st_nxt.s_low = 1'h0;
      st_nxt.snack = 1'h0;
    end else if (stop_det) begin
      st_nxt.ssel = 1'h0;
      st_nxt.s_low = 1'h0;
    end else if (scl_rise) begin
      if (st_r.scnt < 4'h8) begin
        st_nxt.srx = {st_r.srx[6:0], sda_i};
        st_nxt.scnt = st_r.scnt + 4'h1;
      end else if (st_r.scnt == 4'h9) begin
        st_nxt.snack = sda_i;
      end
    end else if (scl_fall) begin
      if (st_r.scnt == 4'h8) begin
        st_nxt.scnt = 4'h9;
        st_nxt.s_low = 1'h0;
        if (st_r.sfirst) begin
          if (!st_r.mown && ((st_r.srx[7:1] == st_r.own[7:1]) ||
              (st_r.ctrl[CTRL_SEC_EN] && (st_r.srx[7:1] == st_r.sec[7:1])))) begin
            st_nxt.ssel = 1'h1;
            st_nxt.srw = st_r.srx[0];
            st_nxt.s_low = 1'h1;
          end
        end else if (st_r.ssel && !st_r.srw) begin
          st_nxt.data = st_r.srx;
          st_nxt.full = 1'h1;
          st_nxt.s_low = ~st_r.ctrl[CTRL_TXAK];
        end
      end else if (st_r.scnt == 4'h9) begin
        st_nxt.scnt = 4'h0;
        st_nxt.sfirst = 1'h0;
        st_nxt.s_low = 1'h0;
        if (st_r.ssel && st_r.srw) begin
          if (st_r.snack) begin
            st_nxt.ssel = 1'h0;
          end else begin
            st_nxt.stx = st_r.data;
            st_nxt.full = 1'h0;
            st_nxt.s_low = ~st_r.data[7];
          end
        end
      end else if (st_r.ssel && st_r.srw && (st_r.scnt != 4'h0)) begin
        st_nxt.stx = {st_r.stx[6:0], 1'h0};
        st_nxt.s_low = ~st_r.stx[6];
      end
    end

    if (lto_pulse) st_nxt.lto = 1'h1;
    st_nxt.scl_oe_n = ~st_nxt.mscl_low;
    st_nxt.sda_oe_n = ~(st_nxt.msda_low | st_nxt.s_low);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.waitreq <= 1'h1;
      st_r.ctrl <= CTRL_RST;
      st_r.own <= OWN_RST;
      st_r.sec <= SEC_RST;
      st_r.lth <= LTH_RST;
      st_r.ltl <= LTL_RST;
      st_r.ms <= MS_IDLE;
      st_r.scl_p <= 1'h1;
      st_r.sda_p <= 1'h1;
      st_r.scl_oe_n <= 1'h1;
      st_r.sda_oe_n <= 1'h1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign scl_o = st_r.pin_lvl;
  assign sda_o = st_r.pin_lvl;
  assign scl_oe_n = st_r.scl_oe_n;
  assign sda_oe_n = st_r.sda_oe_n;
endmodule : isbe_engine
`default_nettype wire

// [inc/isbe_pkg.sv]
// Purpose: shared constants and types of the two-wire bus engine
// Assumes: word-indexed register map, byte address is four times the index
// Notes: all timing counts derive from the 50 MHz module clock
`default_nettype none
package isbe_pkg;
  // register indices
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_OWN = 4'h1;
  localparam logic [3:0] IDX_DATA = 4'h2;
  localparam logic [3:0] IDX_STAT = 4'h3;
  localparam logic [3:0] IDX_CMD = 4'h4;
  localparam logic [3:0] IDX_SEC = 4'h9;
  localparam logic [3:0] IDX_LTH = 4'hA;
  localparam logic [3:0] IDX_LTL = 4'hB;
  localparam logic [3:0] IDX_BUF = 4'hC;
  // control fields
  localparam int CTRL_TXAK = 0;
  localparam int CTRL_SEC_EN = 1;
  localparam int CTRL_TCK_SEL = 2;
  localparam logic [7:0] CTRL_MASK = 8'h07;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_MOWN = 1;
  localparam int ST_ARB = 2;
  localparam int ST_NACK = 3;
  localparam int ST_DONE = 4;
  localparam int ST_SEL = 5;
  localparam int ST_LTO = 6;
  localparam int ST_CERR = 7;
  // buffer status fields
  localparam int BUF_EMPTY = 0;
  localparam int BUF_ERR = 1;
  // commands
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_TX = 3'h2;
  localparam logic [2:0] CMD_RX = 3'h3;
  localparam logic [2:0] CMD_STOP = 3'h4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] SEC_RST = 8'h00;
  localparam logic [7:0] LTH_RST = 8'h00;
  localparam logic [7:0] LTL_RST = 8'h00;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_HALF_NS = 5000;
  localparam int unsigned HALF_CYC = (T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TO_PRESCALE = 64;
  localparam logic [1:0] ERR_LIMIT = 2'h3;
  typedef enum logic [8:0] {
    MS_IDLE = 9'h001,
    MS_REL = 9'h002,
    MS_SETUP = 9'h004,
    MS_STA = 9'h008,
    MS_LOW = 9'h010,
    MS_HIGH = 9'h020,
    MS_HOLD = 9'h040,
    MS_STP1 = 9'h080,
    MS_STPE = 9'h100
  } isbe_mstate_t;
endpackage : isbe_pkg
`default_nettype wire

// [rtl/isbe_timeout.sv]
// Purpose: clock-line low timeout counter
// Assumes: scl_i synchronous to clk
// Notes: expired pulses once per low period
`timescale 1ns/10ps
`default_nettype none
module isbe_timeout
  import isbe_pkg::*;
#(
  parameter int unsigned PRESCALE = TO_PRESCALE
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic fast_sel,
  input wire logic [15:0] limit,
  output logic expired
);
  localparam int PW = $clog2(PRESCALE);
  typedef struct packed {
    logic [PW-1:0] pre;
    logic [15:0] cnt;
    logic fired;
    logic expired;
  } isbe_to_state_t;
  isbe_to_state_t st_r;
  isbe_to_state_t st_nxt;
  logic tick;

  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'h0;
    tick = fast_sel | (st_r.pre == PW'(PRESCALE - 1));
    st_nxt.pre = tick ? '0 : st_r.pre + PW'(1);
    if (scl_i || (limit == 16'h0000)) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.fired = 1'h0;
    end else if (tick && !st_r.fired) begin
      if (st_r.cnt == limit - 16'h0001) begin
        st_nxt.expired = 1'h1;
        st_nxt.fired = 1'h1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;
endmodule : isbe_timeout
`default_nettype wire

// [bench/isbe_engine_props.sv]
// Purpose: port level checks of the bus engine
// Assumes: ce held high, HALF_CYCLES set to 4 by the bench
// Notes: bound into every engine instance
`timescale 1ns/10ps
`default_nettype none
module isbe_engine_props
  import isbe_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  property p_answer;
    s_req |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_one_cycle;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer longer than one cycle");
  property p_no_spurious;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_wired;
    scl_o == 1'h0 && sda_o == 1'h0;
  endproperty
  a_wired: assert property (p_wired) else $error("line driven high");
  property p_sec0;
    s_rd_done ##0 (avs_address == IDX_SEC) |-> avs_readdata[0] == 1'h0;
  endproperty
  a_sec0: assert property (p_sec0) else $error("second address bit 0 set");
  property p_upper;
    s_rd_done |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_start;
    $fell(sda_oe_n) && scl_i |-> $past(scl_i) && $past(sda_i);
  endproperty
  a_start: assert property (p_start) else $error("data pulled while clock high on busy bus");
  property p_low;
    $fell(scl_oe_n) |-> !scl_oe_n [*4];
  endproperty
  a_low: assert property (p_low) else $error("clock low period too short");
  property p_reset;
    $fell(srst) |-> avs_waitrequest && scl_oe_n && sda_oe_n;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule : isbe_engine_props
bind isbe_engine isbe_engine_props #(.HALF_CYCLES(HALF_CYCLES)) isbe_engine_props_inst (
  .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n));
`default_nettype wire

// [bench/isbe_slave_model.sv]
// Purpose: behavioural slave device on the two-wire bus
// Assumes: write transfers only, lines sampled on clk
// Notes: acks its address and every data byte while selected
`timescale 1ns/10ps
`default_nettype none
module isbe_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic [7:0] last_byte
);
  logic scl_q = 1'h1;
  logic sda_q = 1'h1;
  logic addr_ph = 1'h0;
  logic sel = 1'h0;
  logic [7:0] sh = 8'h00;
  int cnt = 0;
  initial sda_pull = 1'h0;
  initial last_byte = 8'h00;
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 0;
      addr_ph <= 1'h1;
      sel <= 1'h0;
    // msb first, taken on rising clock
    end else if (scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      cnt <= cnt + 1;
    end else if (!scl && scl_q && cnt == 8) begin
      sel <= addr_ph ? (sh[7:1] == ADDR) : sel;
      sda_pull <= addr_ph ? (sh[7:1] == ADDR) : sel;
      last_byte <= (!addr_ph && sel) ? sh : last_byte;
    end else if (!scl && scl_q && cnt == 9) begin
      sda_pull <= 1'h0;
      cnt <= 0;
      addr_ph <= 1'h0;
    end
  end
endmodule : isbe_slave_model
`default_nettype wire

// [bench/isbe_engine_tb.sv]
// Purpose: self-checking bench of the bus engine
// Assumes: ce tied high, short half period
// Notes: reads are checked by a monitor against queued notes
`timescale 1ns/10ps
`default_nettype none
module isbe_engine_tb;
  import isbe_pkg::*;
  localparam int unsigned HALF = 4;
  localparam logic [6:0] SLV = 7'h50;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_i, sda_i, slv_pull;
  logic pull_scl = 1'h0;
  logic [7:0] slv_byte, pv, r, d, me, mm;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int seed = 77606;
  always #10 clk = ~clk;
  assign scl_i = scl_oe_n & ~pull_scl;
  assign sda_i = sda_oe_n & ~slv_pull;
  isbe_engine #(.HALF_CYCLES(HALF)) isbe_engine_inst (.clk(clk), .srst(srst), .ce(1'h1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  isbe_slave_model #(.ADDR(SLV)) isbe_slave_model_inst (.clk(clk), .scl(scl_i), .sda(sda_i),
    .sda_pull(slv_pull), .last_byte(slv_byte));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] v,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, v};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 40);
    if (n >= 40) miscompares++;
    pv = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus(a, 1'h1, v, 4'hF);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'h0, 8'h00, 4'hF);
  endtask : rd
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      rd(a, 8'h00, 8'h00);
      k++;
    end while (pv[b] !== v && k < 300);
    if (k >= 300) miscompares++;
  endtask : poll
  // hold the clock line low from outside, then read the timeout flag
  task automatic tmo(input int n, input logic [7:0] e);
    @(posedge clk);
    pull_scl <= 1'h1;
    repeat (n) @(posedge clk);
    pull_scl <= 1'h0;
    rd(IDX_STAT, e, 8'h40);
  endtask : tmo
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'h0) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      check("readdata", avs_readdata[7:0] & mm, me);
    end
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    rd(IDX_SEC, SEC_RST, 8'hFF);
    rd(IDX_LTH, LTH_RST, 8'hFF);
    rd(IDX_LTL, LTL_RST, 8'hFF);
    rd(IDX_BUF, 8'h01, 8'hFF);
    rd(4'h7, 8'h00, 8'hFF);
    $display("test reset values done");
    for (int i = 9; i < 12; i++) begin
      r = 8'($random(seed));
      wr(4'(i), r);
      bus(4'(i), 1'h1, ~r, 4'h0);
      rd(4'(i), (i == 9) ? (r & 8'hFE) : r, 8'hFF);
      wr(4'(i), 8'h00);
    end
    $display("test register access done");
    wr(IDX_OWN, 8'h40);
    wr(IDX_DATA, 8'h66);
    wr(IDX_CMD, {5'h0, CMD_START});
    poll(IDX_STAT, ST_DONE, 1'h1);
    rd(IDX_STAT, 8'h08, 8'h08);
    wr(IDX_STAT, 8'h10);
    wr(IDX_DATA, {SLV, 1'h0});
    wr(IDX_CMD, {5'h0, CMD_START});
    poll(IDX_STAT, ST_DONE, 1'h1);
    rd(IDX_STAT, 8'h13, 8'hFF);
    rd(IDX_BUF, 8'h01, 8'hFF);
    wr(IDX_STAT, 8'h10);
    d = 8'($random(seed));
    wr(IDX_DATA, d);
    rd(IDX_BUF, 8'h00, 8'hFF);
    wr(IDX_DATA, ~d);
    wr(IDX_DATA, ~d);
    rd(IDX_BUF, 8'h00, 8'hFF);
    wr(IDX_DATA, ~d);
    rd(IDX_BUF, 8'h02, 8'hFF);
    wr(IDX_CMD, {5'h0, CMD_TX});
    poll(IDX_STAT, ST_DONE, 1'h1);
    check("slave byte", slv_byte, d);
    wr(IDX_BUF, 8'h02);
    rd(IDX_BUF, 8'h01, 8'hFF);
    wr(IDX_STAT, 8'h10);
    wr(IDX_CMD, {5'h0, CMD_RX});
    poll(IDX_STAT, ST_DONE, 1'h1);
    // nobody drives data, so a released line reads as all ones
    rd(IDX_DATA, 8'hFF, 8'hFF);
    wr(IDX_STAT, 8'h10);
    wr(IDX_CMD, {5'h0, CMD_STOP});
    poll(IDX_STAT, ST_BUSY, 1'h0);
    rd(IDX_STAT, 8'h00, 8'h0B);
    $display("test master transfers done");
    wr(IDX_DATA, 8'h40);
    wr(IDX_CMD, {5'h0, CMD_START});
    rd(IDX_STAT, 8'h80, 8'h81);
    wr(IDX_STAT, 8'h80);
    $display("test own address refused done");
    wr(IDX_LTL, 8'h03);
    wr(IDX_CTRL, 8'h04);
    tmo(10, 8'h40);
    wr(IDX_STAT, 8'h40);
    rd(IDX_STAT, 8'h00, 8'h40);
    wr(IDX_CTRL, 8'h00);
    tmo(20, 8'h00);
    tmo(300, 8'h40);
    wr(IDX_STAT, 8'h40);
    wr(IDX_LTL, 8'h00);
    wr(IDX_CTRL, 8'h04);
    tmo(20, 8'h00);
    $display("test low timeout done");
    conclude();
  end
endmodule : isbe_engine_tb
`default_nettype wire
